// File: slpa_cfg.svh
// Constants for the stack limit and program space addressing block
`ifndef SLPA_CFG_SVH
`define SLPA_CFG_SVH
`define SLPA_OFS_STACK_LIMIT 8'h00
`define SLPA_OFS_TABLE_PAGE  8'h04
`define SLPA_OFS_VIS_PAGE    8'h08
`define SLPA_OFS_STATUS      8'h0C
`define SLPA_OFS_MASK        8'h10
`define SLPA_OFS_STACK_PTR   8'h14
`define SLPA_RAM_START       16'h0800
`define SLPA_TBL_CFG_BIT     7
`define SLPA_EA_VIS_BIT      15
`define SLPA_ST_OVF_BIT      0
`define SLPA_ST_UNF_BIT      1
`define SLPA_SP_RESET        16'h0800
`define SLPA_PAGE_RESET      8'h00
`endif

// File: slpa_map_if.sv
// Interface between the top and the program address mapper
`timescale 1ns/1ns
interface slpa_map_if;
   logic [15:0] effective_addr;   // Data effective address
   logic [7:0]  table_page_reg;   // Table page
   logic [7:0]  visibility_page_reg; // Visibility page
   logic [23:0] tbl_addr;         // Table program address
   logic        tbl_config;       // Table targets configuration memory
   logic [22:0] vis_addr;         // Remapped program address
   logic        vis_hit;          // Address falls in the window
   modport top (output effective_addr, table_page_reg,
                visibility_page_reg,
                input tbl_addr, tbl_config, vis_addr, vis_hit);
   modport mapper (input effective_addr, table_page_reg,
                   visibility_page_reg,
                   output tbl_addr, tbl_config, vis_addr, vis_hit);
endinterface

// File: slpa_mapper.sv
// Program address formation for table and remapped accesses
`timescale 1ns/1ns
`include "slpa_cfg.svh"
module slpa_mapper (
   slpa_map_if.mapper m   // Address mapping signals
);
   // Table address: page above the 16-bit effective address
   assign m.tbl_addr   = {m.table_page_reg, m.effective_addr};
   assign m.tbl_config = m.table_page_reg[`SLPA_TBL_CFG_BIT];
   // Window: page joined with low 15 bits, user memory only
   assign m.vis_hit  = m.effective_addr[`SLPA_EA_VIS_BIT];
   assign m.vis_addr = {m.visibility_page_reg,
                        m.effective_addr[14:0]};
endmodule

// File: slpa_pkg.sv
// Types for the stack limit and program space addressing block
package slpa_pkg;
   typedef enum logic [1:0] {
      SLPA_STK_NONE = 2'b00,
      SLPA_STK_PUSH = 2'b01,
      SLPA_STK_POP  = 2'b10,
      SLPA_STK_EA   = 2'b11
   } slpa_stk_op_t;
   typedef enum logic [1:0] {
      SLPA_PUSH_DATA = 2'b00,
      SLPA_PUSH_CALL = 2'b01,
      SLPA_PUSH_EXC  = 2'b10
   } slpa_push_kind_t;
endpackage

// File: slpa_prog_mem.sv
// Behavioural program memory on the far side of the program port
`timescale 1ns/1ns
module slpa_prog_mem (
   input  wire logic        core_clk,   // Core clock
   input  wire logic [23:0] prog_addr,  // Program word address
   input  wire logic        prog_re,    // Read strobe
   input  wire logic        prog_we,    // Write strobe
   input  wire logic [23:0] prog_wdata, // Write word
   input  wire logic [2:0]  prog_wmask, // Byte lanes
   output logic      [23:0] prog_rdata  // Read word
);
   logic [23:0] mem [16];               // Small slice of 24-bit words
   logic [23:0] last_q;
   // Known pattern at start so that the bench can predict reads
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = {4'hC, i[3:0], 8'h3C, 4'h4, i[3:0]};
      end
      last_q = 24'h000000;
   end
   // Byte-masked writes land on the clock edge
   always @(posedge core_clk) begin
      if (prog_we) begin
         for (int b = 0; b < 3; b++) begin
            if (prog_wmask[b]) begin
               mem[prog_addr[3:0]][b*8 +: 8] <= prog_wdata[b*8 +: 8];
            end
         end
      end
      if (prog_re) begin
         last_q <= mem[prog_addr[3:0]];
      end
   end
   // Released bus shows the inverse of the last word, never a stale copy
   assign prog_rdata = prog_re ? mem[prog_addr[3:0]] : ~last_q;
endmodule

// File: slpa_top.sv
// Stack limit checking and program space addressing block
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "slpa_cfg.svh"
module slpa_top #(
   parameter int DW = 16,           // Data word width
   parameter int PW = 24            // Program word width
) (
   input  wire logic                     core_clk,      // Core clock
   input  wire logic                     rst_b,         // Async reset, low
   // Wishbone slave
   input  wire logic                     wb_cyc_i,      // Cycle
   input  wire logic                     wb_stb_i,      // Strobe
   input  wire logic                     wb_we_i,       // Write enable
   input  wire logic [7:0]               wb_adr_i,      // Byte address
   input  wire logic [3:0]               wb_sel_i,      // Byte lanes
   input  wire logic [31:0]              wb_dat_i,      // Write data
   output logic      [31:0]              wb_dat_o,      // Read data
   output logic                          wb_ack_o,      // Acknowledge
   output logic                          irq,           // Stack error irq
   // Stack requests from the sequencer
   input  wire slpa_pkg::slpa_stk_op_t   stk_op,        // Stack operation
   input  wire slpa_pkg::slpa_push_kind_t push_kind,    // Push format
   input  wire logic [DW-1:0]            push_data,     // Data to push
   input  wire logic [PW-1:0]            push_pc,       // Counter to push
   input  wire logic [7:0]               status_low_byte, // Status low
   input  wire logic [DW-1:0]            stk_ea,        // Stack pointer EA
   output logic      [DW-1:0]            stk_addr,      // Stack data addr
   output logic      [DW-1:0]            stk_wdata,     // Pushed word
   output logic                          stk_wdata_hi,  // Second word flag
   output logic                          stack_trap,    // Trap request
   // Program space access
   input  wire logic [DW-1:0]            effective_addr, // Data EA
   input  wire logic                     tbl_req,       // Table access
   input  wire logic                     tbl_we,        // Table write
   input  wire logic                     tbl_hi,        // Upper byte select
   input  wire logic [DW-1:0]            tbl_wdata,     // Table write data
   input  wire logic                     vis_req,       // Remapped read
   input  wire logic [PW-1:0]            prog_rdata,    // Program word in
   output logic      [PW-1:0]            prog_addr,     // Program address
   output logic                          prog_config,   // Config memory
   output logic                          prog_re,       // Program read
   output logic                          prog_we,       // Program write
   output logic      [PW-1:0]            prog_wdata,    // Program word out
   output logic      [2:0]               prog_wmask,    // Byte write mask
   output logic      [DW-1:0]            prog_rword,    // Data-side result
   output logic                          vis_valid      // Window read hit
);
   import slpa_pkg::*;

   logic [DW-1:0] stack_pointer_reg_q;
   logic [DW-1:0] stack_limit_reg_q;
   logic [7:0]    table_page_reg_q;
   logic [7:0]    visibility_page_reg_q;
   logic [1:0]    status_q;
   logic [1:0]    mask_q;
   logic [1:0]    pc_words_q;
   logic          wb_ack_q;
   logic [31:0]   wb_dat_q;
   logic          push_ev;
   logic          pop_ev;
   logic          ovf_ev;
   logic          unf_ev;
   logic          wr_acc;
   logic          rd_acc;
   logic [DW-1:0] stk_ea_sel;
   logic [DW-1:0] pc_hi_word;

   slpa_map_if map_if ();

   slpa_mapper u_mapper (
      .m (map_if.mapper)
   );

   // Register address decode, used by the write paths; the read path decodes with a case
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   // Bus request seen once: ack drops the cycle after it is given
   assign wr_acc = wb_cyc_i && wb_stb_i && !wb_ack_q && wb_we_i;
   assign rd_acc = wb_cyc_i && wb_stb_i && !wb_ack_q && !wb_we_i;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_q <= 1'b0;
      end else begin
         wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;

   // Stack requests
   assign push_ev = (stk_op == SLPA_STK_PUSH);
   assign pop_ev  = (stk_op == SLPA_STK_POP);

   // Call and exception pushes with a counter span two words; exceptions put the status byte in the upper word
   assign pc_hi_word = (push_kind == SLPA_PUSH_EXC) ?
                       {status_low_byte, push_pc[23:16]} :
                       {8'h00, push_pc[23:16]};

   // Address used for the check: pointer minus 2 for pop, EA for EA ops, pointer otherwise
   always_comb begin
      unique case (stk_op)
         SLPA_STK_POP:  stk_ea_sel = stack_pointer_reg_q - 16'h0002;
         SLPA_STK_EA:   stk_ea_sel = stk_ea;
         default:       stk_ea_sel = stack_pointer_reg_q;
      endcase
   end

   // Overflow: pushing past the limit; a push at the limit is allowed
   assign ovf_ev = push_ev &&
                   (stk_ea_sel > stack_limit_reg_q);
   // Underflow guards the special register space
   assign unf_ev = (stk_op != SLPA_STK_NONE) &&
                   (stk_ea_sel < `SLPA_RAM_START);

   // Trap lasts exactly the offending access cycle
   assign stack_trap = ovf_ev || unf_ev;

   // Stack address and data: write at the free word before increment
   always_comb begin
      stk_addr     = stk_ea_sel;
      stk_wdata_hi = 1'b0;
      stk_wdata    = push_data;
      if (push_ev && push_kind != SLPA_PUSH_DATA) begin
         stk_wdata_hi = (pc_words_q == 2'd1);
         stk_wdata    = (pc_words_q == 2'd1) ? pc_hi_word :
                        push_pc[15:0];
      end
   end

   // Counter pushes: low word first, then the upper word
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_words_q <= 2'd0;
      end else if (push_ev && push_kind != SLPA_PUSH_DATA) begin
         pc_words_q <= (pc_words_q == 2'd1) ? 2'd0 : 2'd1;
      end else begin
         pc_words_q <= 2'd0;
      end
   end

   // Stack pointer: bus writes, post-increment on push, predecrement on pop
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stack_pointer_reg_q <= `SLPA_SP_RESET;
      end else if (push_ev) begin
         stack_pointer_reg_q <= stack_pointer_reg_q + 16'h0002;
      end else if (pop_ev) begin
         stack_pointer_reg_q <= stk_ea_sel;
      end else if (wr_acc && hit(wb_adr_i, `SLPA_OFS_STACK_PTR)
                   && wb_sel_i[1:0] == 2'b11) begin
         stack_pointer_reg_q <= {wb_dat_i[15:1], 1'b0};
      end
   end

   // Stack limit: no defined reset value, bit 0 forced clear
   always_ff @(posedge core_clk) begin
      if (wr_acc && hit(wb_adr_i, `SLPA_OFS_STACK_LIMIT)) begin
         if (wb_sel_i[0]) begin
            stack_limit_reg_q[7:0] <= {wb_dat_i[7:1], 1'b0};
         end
         if (wb_sel_i[1]) begin
            stack_limit_reg_q[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // Page registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         table_page_reg_q      <= `SLPA_PAGE_RESET;
         visibility_page_reg_q <= `SLPA_PAGE_RESET;
      end else if (wr_acc && wb_sel_i[0]) begin
         if (hit(wb_adr_i, `SLPA_OFS_TABLE_PAGE)) begin
            table_page_reg_q <= wb_dat_i[7:0];
         end
         if (hit(wb_adr_i, `SLPA_OFS_VIS_PAGE)) begin
            visibility_page_reg_q <= wb_dat_i[7:0];
         end
      end
   end

   // Sticky status: hardware set wins over write-one-to-clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q <= 2'b00;
      end else begin
         if (ovf_ev) begin
            status_q[`SLPA_ST_OVF_BIT] <= 1'b1;
         end else if (wr_acc && hit(wb_adr_i, `SLPA_OFS_STATUS)
                      && wb_sel_i[0] && wb_dat_i[`SLPA_ST_OVF_BIT]) begin
            status_q[`SLPA_ST_OVF_BIT] <= 1'b0;
         end
         if (unf_ev) begin
            status_q[`SLPA_ST_UNF_BIT] <= 1'b1;
         end else if (wr_acc && hit(wb_adr_i, `SLPA_OFS_STATUS)
                      && wb_sel_i[0] && wb_dat_i[`SLPA_ST_UNF_BIT]) begin
            status_q[`SLPA_ST_UNF_BIT] <= 1'b0;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= 2'b00;
      end else if (wr_acc && hit(wb_adr_i, `SLPA_OFS_MASK) && wb_sel_i[0]) begin
         mask_q <= wb_dat_i[1:0];
      end
   end

   assign irq = |(status_q & mask_q);

   // Read data; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_q <= 32'h00000000;
      end else if (rd_acc) begin
         unique case (wb_adr_i)
            `SLPA_OFS_STACK_LIMIT: wb_dat_q <= {16'h0000,
                                   stack_limit_reg_q[15:1], 1'b0};
            `SLPA_OFS_TABLE_PAGE:  wb_dat_q <= {24'h000000, table_page_reg_q};
            `SLPA_OFS_VIS_PAGE:    wb_dat_q <= {24'h000000,
                                   visibility_page_reg_q};
            `SLPA_OFS_STATUS:      wb_dat_q <= {30'h00000000, status_q};
            `SLPA_OFS_MASK:        wb_dat_q <= {30'h00000000, mask_q};
            `SLPA_OFS_STACK_PTR:   wb_dat_q <= {16'h0000, stack_pointer_reg_q};
            default:               wb_dat_q <= 32'h00000000;
         endcase
      end
   end

   // Program space mapping
   assign map_if.effective_addr      = effective_addr;
   assign map_if.table_page_reg      = table_page_reg_q;
   assign map_if.visibility_page_reg = visibility_page_reg_q;

   // Table path has priority; window only for EAs with top bit set
   always_comb begin
      prog_addr   = {PW{1'b0}};
      prog_config = 1'b0;
      prog_re     = 1'b0;
      prog_we     = 1'b0;
      prog_wdata  = {PW{1'b0}};
      prog_wmask  = 3'b000;
      if (tbl_req) begin
         prog_addr   = map_if.tbl_addr;
         prog_config = map_if.tbl_config;
         prog_re     = !tbl_we;
         prog_we     = tbl_we;
         prog_wdata  = tbl_hi ? {tbl_wdata[7:0], 16'h0000} :
                       {8'h00, tbl_wdata};
         prog_wmask  = tbl_hi ? 3'b100 : 3'b011;
      end else if (vis_req && map_if.vis_hit) begin
         prog_addr = {1'b0, map_if.vis_addr};
         prog_re   = 1'b1;
      end
   end

   // Returned data word registered; window keeps low word only
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_rword <= 16'h0000;
         vis_valid  <= 1'b0;
      end else begin
         vis_valid <= vis_req && !tbl_req && map_if.vis_hit;
         if (tbl_req && !tbl_we) begin
            prog_rword <= tbl_hi ? {8'h00, prog_rdata[23:16]} :
                          prog_rdata[15:0];
         end else if (vis_req && map_if.vis_hit) begin
            prog_rword <= prog_rdata[15:0];
         end
      end
   end

   // Checks
   sequence push_at_limit_s;
      push_ev && stk_ea_sel == stack_limit_reg_q;
   endsequence

   // Pointer has moved past the limit by the following push
   sequence next_push_s;
      push_ev;
   endsequence

   push_limit_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (push_at_limit_s and stk_ea_sel >= `SLPA_RAM_START) |-> !stack_trap)
      else $error("push at limit trapped");
   limit_next_trap_a: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      push_at_limit_s ##1 next_push_s |-> stack_trap)
      else $error("push after limit not trapped");
   push_past_trap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      push_ev && stk_ea_sel > stack_limit_reg_q |-> stack_trap)
      else $error("push past limit missed");
   under_trap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      stk_op == SLPA_STK_EA && stk_ea < 16'h0800 |-> stack_trap)
      else $error("underflow missed");
   push_incr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      push_ev |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) + 16'h0002)
      else $error("push increment wrong");
   pop_decr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      pop_ev |-> stk_addr == stack_pointer_reg_q - 16'h0002)
      else $error("pop address wrong");
   call_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      push_ev && push_kind == SLPA_PUSH_CALL && stk_wdata_hi
      |-> stk_wdata[15:8] == 8'h00)
      else $error("call upper byte not clear");
   exc_status_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      push_ev && push_kind == SLPA_PUSH_EXC && stk_wdata_hi
      |-> stk_wdata[15:8] == status_low_byte)
      else $error("status byte missing");
   limit_bit0_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      rd_acc && wb_adr_i == `SLPA_OFS_STACK_LIMIT |=> wb_dat_o[0] == 1'b0)
      else $error("limit bit 0 set");
   tbl_addr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      tbl_req |-> prog_addr == {table_page_reg_q, effective_addr}
      && prog_config == table_page_reg_q[7])
      else $error("table address wrong");
   vis_addr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      vis_req && !tbl_req && effective_addr[15]
      |-> prog_addr == {1'b0, visibility_page_reg_q, effective_addr[14:0]}
      && !prog_we ##1 vis_valid)
      else $error("window address wrong");
   trap_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      stk_op == SLPA_STK_NONE |-> !stack_trap)
      else $error("trap not tied to access");
endmodule

// File: testbench.sv
// Self-checking bench for the stack limit and program space block
`timescale 1ns/1ns
`include "slpa_cfg.svh"
module testbench;
   import slpa_pkg::*;
   logic            core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i;
   logic            wb_ack_o, irq, stk_wdata_hi, stack_trap, vis_valid;
   logic            tbl_req, tbl_we, tbl_hi, vis_req, prog_config;
   logic            prog_re, prog_we;
   logic [7:0]      wb_adr_i, status_low_byte;
   logic [3:0]      wb_sel_i;
   logic [2:0]      prog_wmask;
   logic [31:0]     wb_dat_i, wb_dat_o, rd;
   logic [15:0]     push_data, stk_ea, stk_addr, stk_wdata;
   logic [15:0]     effective_addr, tbl_wdata, prog_rword;
   logic [23:0]     push_pc, prog_rdata, prog_addr, prog_wdata;
   slpa_stk_op_t    stk_op;
   slpa_push_kind_t push_kind;
   int              bad_count, n_compared;
   slpa_top DUT (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq(irq), .stk_op(stk_op),
      .push_kind(push_kind), .push_data(push_data), .push_pc(push_pc),
      .status_low_byte(status_low_byte), .stk_ea(stk_ea),
      .stk_addr(stk_addr), .stk_wdata(stk_wdata),
      .stk_wdata_hi(stk_wdata_hi), .stack_trap(stack_trap),
      .effective_addr(effective_addr), .tbl_req(tbl_req), .tbl_we(tbl_we),
      .tbl_hi(tbl_hi), .tbl_wdata(tbl_wdata), .vis_req(vis_req),
      .prog_rdata(prog_rdata), .prog_addr(prog_addr),
      .prog_config(prog_config), .prog_re(prog_re), .prog_we(prog_we),
      .prog_wdata(prog_wdata), .prog_wmask(prog_wmask),
      .prog_rword(prog_rword), .vis_valid(vis_valid));
   slpa_prog_mem far (.core_clk(core_clk), .prog_addr(prog_addr),
      .prog_re(prog_re), .prog_we(prog_we), .prog_wdata(prog_wdata),
      .prog_wmask(prog_wmask), .prog_rdata(prog_rdata));
   // Free-running core clock, 20 ns period
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic end_of_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One classic cycle; ack and read data are taken at the same rising edge
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat, input logic [3:0] sel);
      int n;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      n = 0;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && n < 16) begin
         n++;
         @(posedge core_clk);
      end
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   // One cycle of stack traffic; outputs are judged at the falling edge
   task automatic stk(input slpa_stk_op_t op, input slpa_push_kind_t kind,
                      input logic [15:0] val);
      @(posedge core_clk);
      stk_op    <= op;
      push_kind <= kind;
      stk_ea    <= val;
      push_data <= val;
      @(negedge core_clk);
   endtask
   // Reset values, an unmapped place and the limit alignment
   task automatic t_regs;
      logic [7:0] ofs [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
      wb(1'b0, `SLPA_OFS_STACK_PTR, 32'h0, 4'hF);
      check(rd, 32'h0000_0800);
      foreach (ofs[i]) begin
         wb(1'b0, ofs[i], 32'h0, 4'hF);
         check(rd, 32'h0000_0000);
      end
      wb(1'b1, `SLPA_OFS_STACK_LIMIT, 32'h0000_0DF5, 4'hF);
      wb(1'b0, `SLPA_OFS_STACK_LIMIT, 32'h0, 4'hF);
      check(rd, 32'h0000_0DF4);
      wb(1'b1, `SLPA_OFS_STACK_PTR, 32'h0000_1234, 4'h1);
      wb(1'b0, `SLPA_OFS_STACK_PTR, 32'h0, 4'hF);
      check(rd, 32'h0000_0800);
   endtask
   // Push and pop order, limit boundary, one-cycle trap, status and irq
   task automatic t_push;
      wb(1'b1, `SLPA_OFS_STACK_PTR, 32'h0000_0DF0, 4'hF);
      stk(SLPA_STK_PUSH, SLPA_PUSH_DATA, 16'hA000);
      check(stk_addr, 16'h0DF0);
      check(stk_wdata, 16'hA000);
      stk(SLPA_STK_POP, SLPA_PUSH_DATA, 16'h0000);
      check(stk_addr, 16'h0DF0);
      for (int i = 0; i < 4; i++) begin
         stk(SLPA_STK_PUSH, SLPA_PUSH_DATA, 16'hA000 + 16'(i));
         check(stk_addr, 16'h0DF0 + 16'(2 * i));
         check(stack_trap, (i == 3));
      end
      stk(SLPA_STK_NONE, SLPA_PUSH_DATA, 16'h0000);
      check(stack_trap, 1'b0);
      wb(1'b0, `SLPA_OFS_STATUS, 32'h0, 4'hF);
      check(rd[1:0], 2'b01);
      check(irq, 1'b0);
      wb(1'b1, `SLPA_OFS_MASK, 32'h0000_0003, 4'hF);
      @(negedge core_clk);
      check(irq, 1'b1);
      wb(1'b1, `SLPA_OFS_STATUS, 32'h0000_0001, 4'hF);
      @(negedge core_clk);
      check(irq, 1'b0);
   endtask
   // Counter pushes for calls and exceptions, then underflow checks
   task automatic t_pc;
      slpa_push_kind_t k;
      // The limit is raised out of the way and the pointer set before the counter pushes
      wb(1'b1, `SLPA_OFS_STACK_LIMIT, 32'h0000_FFFE, 4'hF);
      wb(1'b1, `SLPA_OFS_STACK_PTR, 32'h0000_0900, 4'hF);
      push_pc         <= 24'hABCDEF;
      status_low_byte <= 8'h5C;
      for (int j = 0; j < 2; j++) begin
         k = j ? SLPA_PUSH_EXC : SLPA_PUSH_CALL;
         stk(SLPA_STK_PUSH, k, 16'h0000);
         check({stk_wdata_hi, stk_wdata}, 17'h0CDEF);
         stk(SLPA_STK_PUSH, k, 16'h0000);
         check({stk_wdata_hi, stk_wdata}, {1'b1, j ? 8'h5C : 8'h00, 8'hAB});
      end
      stk(SLPA_STK_EA, SLPA_PUSH_DATA, 16'h07FE);
      check(stack_trap, 1'b1);
      stk(SLPA_STK_EA, SLPA_PUSH_DATA, 16'h0800);
      check(stack_trap, 1'b0);
      stk(SLPA_STK_NONE, SLPA_PUSH_DATA, 16'h0000);
      check(irq, 1'b1);
      wb(1'b0, `SLPA_OFS_STATUS, 32'h0, 4'hF);
      check(rd[1:0], 2'b10);
      wb(1'b1, `SLPA_OFS_STATUS, 32'h0000_0002, 4'hF);
   endtask
   // Table page forming, configuration select and byte writes
   task automatic t_table;
      wb(1'b1, `SLPA_OFS_TABLE_PAGE, 32'h0000_0085, 4'hF);
      effective_addr <= 16'h1234;
      tbl_req        <= 1'b1;
      @(negedge core_clk);
      check(prog_addr, 24'h851234);
      check({prog_config, prog_re, prog_we}, 3'b110);
      wb(1'b1, `SLPA_OFS_TABLE_PAGE, 32'h0000_0005, 4'hF);
      effective_addr <= 16'h0003;
      tbl_we         <= 1'b1;
      tbl_wdata      <= 16'hBEEF;
      @(negedge core_clk);
      check({prog_config, prog_we, prog_wmask}, 5'b01011);
      check(prog_rword, 16'h3C44);
      check(prog_wdata[15:0], 16'hBEEF);
      @(posedge core_clk);
      tbl_hi    <= 1'b1;
      tbl_wdata <= 16'h00A5;
      @(negedge core_clk);
      check({prog_we, prog_wmask}, 4'b1100);
      check(prog_wdata, 24'hA50000);
      @(posedge core_clk);
      tbl_we <= 1'b0;
      @(negedge core_clk);
      check(far.mem[3], 24'hA5BEEF);
      // Upper byte read back through the table path
      @(posedge core_clk);
      tbl_req <= 1'b0;
      tbl_hi  <= 1'b0;
      @(negedge core_clk);
      check(prog_rword, 16'h00A5);
   endtask
   // Remapped reads: address joining, low word only, window miss
   task automatic t_window;
      logic [15:0] ea [3] = '{16'h8003, 16'hFFFF, 16'h7FFF};
      logic [23:0] pa [3] = '{24'h000003, 24'h1E7FFF, 24'h0};
      logic [16:0] rw [3] = '{17'h1BEEF, 17'h13C4F, 17'h0};
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, `SLPA_OFS_VIS_PAGE, (i == 0) ? 32'h0 : 32'h3C, 4'hF);
         effective_addr <= ea[i];
         vis_req        <= 1'b1;
         @(negedge core_clk);
         check(prog_re, (i < 2));
         if (i < 2) begin
            check(prog_addr, pa[i]);
            check({prog_config, prog_we}, 2'b00);
         end
         @(posedge core_clk);
         vis_req <= 1'b0;
         @(negedge core_clk);
         check(vis_valid, rw[i][16]);
         if (i < 2) begin
            check(prog_rword, rw[i][15:0]);
         end
      end
   endtask
   // Main sequence
   initial begin
      bad_count = 0;
      n_compared = 0;
      rst_b = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, tbl_req, tbl_we, tbl_hi} = 6'h00;
      vis_req = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      stk_op = SLPA_STK_NONE;
      push_kind = SLPA_PUSH_DATA;
      {push_data, stk_ea, effective_addr, tbl_wdata} = 64'h0;
      push_pc = 24'h000000;
      status_low_byte = 8'h00;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      t_regs();
      t_push();
      t_pc();
      t_table();
      t_window();
      end_of_test();
   end
endmodule
